// ---- dv/dnc_panel_model.sv ----
// keypad and display model facing the interpreter
`timescale 1ns/1ps
`default_nettype none
module dnc_panel_model
  import dnc_pkg::*;
(
  input  wire logic           ref_clk, // device clock
  input  wire dnc_disp_t      disp,    // display writes
  output logic [DNC_KEY_W-1:0] key_in  // key levels
);
  logic [7:0] scr_chr [0:79];
  logic [7:0] scr_alt [0:79];
  int         n_wr;
  initial key_in = '0;
  // EE marks a cell never written
  task automatic wipe();
    for (int i = 0; i < 80; i++) begin
      scr_chr[i] = 8'hEE;
      scr_alt[i] = 8'hEE;
    end
    n_wr = 0;
  endtask
  // released keys read low; a gap lets the press detector rearm
  task automatic press(input int k, input int hold);
    @(posedge ref_clk);
    key_in <= DNC_KEY_W'(1) << k;
    repeat (hold) @(posedge ref_clk);
    key_in <= '0;
    repeat (6) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (disp.we === 1'b1) begin
      scr_chr[disp.addr] <= disp.chr;
      scr_alt[disp.addr] <= disp.alt;
      n_wr <= n_wr + 1;
    end
  end
endmodule // dnc_panel_model
`default_nettype wire

// ---- dv/dnc_tb_top.sv ----
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
module dnc_tb_top;
  import dnc_pkg::*;
  logic                 ref_clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata, dig_out, rv;
  logic                 pready, pslverr, ev;
  logic [DNC_KEY_W-1:0] key_in;
  dnc_disp_t            disp;
  dnc_cursor_t          cursor;
  logic [7:0]           at [3] = '{8'h00, 8'h20, 8'h5F};
  int                   n_errors = 0;
  int                   tests_run = 0;
  always #4 ref_clk = ~ref_clk;
  dnc_top dnc_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_in(key_in), .disp(disp), .cursor(cursor), .dig_out(dig_out));
  dnc_panel_model dnc_panel_model_inst (.ref_clk(ref_clk), .disp(disp), .key_in(key_in));
  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cb(input int n, input logic [7:0] b);
    wr(DNC_CBUF_BASE + 12'(4 * n), {24'h0, b});
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 300; i++) begin
      rd(DNC_STAT_OFS);
      if (rv[DNC_ST_BUSY] === 1'b0) break;
    end
    if (i == 300) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic scr(input int p, input logic [7:0] c, input logic [7:0] a);
    chk({16'h0, dnc_panel_model_inst.scr_alt[p], dnc_panel_model_inst.scr_chr[p]}, {16'h0, a, c});
  endtask
  task automatic ent(input logic [7:0] s, input logic [7:0] m, input logic [7:0] a);
    wr(DNC_STAT_OFS, 32'h2);
    dnc_panel_model_inst.wipe();
    cb(0, 8'h02);
    cb(1, s);
    cb(2, m);
    cb(3, a);
    wr(DNC_CTRL_OFS, 32'h1);
  endtask
  task automatic resp(input int n, input logic [7:0] c);
    rd(DNC_RESP_BASE + 12'(4 * n));
    chk(rv, {24'h0, c});
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    dnc_panel_model_inst.wipe();
    rd(DNC_STAT_OFS);
    chk(rv & 32'h7, 32'h0);
    rd(12'h010);
    chk({ev, rv[30:0]}, 32'h80000000);
    // steady, space and underscore attributes
    for (int k = 0; k < 3; k++) begin
      cb(0, 8'h01);
      cb(1, 8'(k * 10));
      cb(2, at[k]);
      cb(3, 8'h31);
      cb(4, 8'h32);
      cb(5, 8'h00);
      wr(DNC_CTRL_OFS, 32'h1);
      idle();
      scr(k * 10, 8'h31, at[k]);
      scr(k * 10 + 1, 8'h32, at[k]);
      scr(k * 10 + 2, 8'hEE, 8'hEE);
    end
    dnc_panel_model_inst.wipe();
    cb(1, 8'h00);
    cb(2, 8'h00);
    for (int i = 3; i < 88; i++) cb(i, 8'h41 + 8'(i % 8));
    wr(DNC_CTRL_OFS, 32'h1);
    idle();
    chk(32'(dnc_panel_model_inst.n_wr), 32'h50);
    scr(79, 8'h43, 8'h00);
    dnc_panel_model_inst.wipe();
    cb(1, 8'h4E);
    wr(DNC_CTRL_OFS, 32'h1);
    idle();
    chk(32'(dnc_panel_model_inst.n_wr), 32'h2);
    scr(78, 8'h44, 8'h00);
    rd(DNC_STAT_OFS);
    chk(rv & 32'h2, 32'h0);
    // key levels readable while a key is held, outside any command
    fork
      dnc_panel_model_inst.press(13, 12);
      begin
        repeat (6) @(posedge ref_clk);
        rd(DNC_KEYS_OFS);
      end
    join
    chk(rv, 32'h00002000);
    // entry with every feature; filler bytes 4..83 stay nonzero
    ent(8'h0A, 8'h03, 8'h1F);
    rd(DNC_DOUT_OFS);
    chk(rv, 32'h48474645);
    chk(dig_out, 32'h48474645);
    chk(32'(cursor), 32'h0000022B);
    dnc_panel_model_inst.press(DNC_KEY_SIGN, 3);
    dnc_panel_model_inst.press(5, 8);
    dnc_panel_model_inst.press(DNC_KEY_DOT, 3);
    dnc_panel_model_inst.press(DNC_KEY_LEFT, 3);
    dnc_panel_model_inst.press(7, 3);
    dnc_panel_model_inst.press(9, 3);
    scr(10, 8'h2D, 8'h00);
    scr(11, 8'h35, 8'h00);
    scr(12, 8'h37, 8'h00);
    scr(13, 8'hEE, 8'hEE);
    chk(32'(dnc_panel_model_inst.n_wr), 32'h5);
    dnc_panel_model_inst.press(DNC_KEY_SEND, 3);
    rd(DNC_STAT_OFS);
    chk(rv & 32'h1F07, 32'h0302);
    chk({31'h0, cursor.on}, 32'h0);
    resp(0, 8'h2D);
    resp(1, 8'h35);
    resp(2, 8'h37);
    // sign, dot and echo all disabled
    ent(8'h14, 8'h02, 8'h00);
    dnc_panel_model_inst.press(DNC_KEY_SIGN, 3);
    dnc_panel_model_inst.press(DNC_KEY_DOT, 3);
    dnc_panel_model_inst.press(1, 3);
    dnc_panel_model_inst.press(DNC_KEY_SEND, 3);
    rd(DNC_STAT_OFS);
    chk(rv & 32'h1F07, 32'h0102);
    resp(0, 8'h31);
    chk({30'h0, cursor.block, cursor.flash}, 32'h0);
    chk(32'(dnc_panel_model_inst.n_wr), 32'h0);
    // echo bit set but start position all ones
    ent(DNC_NO_ECHO, 8'h02, 8'h04);
    dnc_panel_model_inst.press(4, 3);
    dnc_panel_model_inst.press(DNC_KEY_SEND, 3);
    chk(32'(dnc_panel_model_inst.n_wr), 32'h0);
    resp(0, 8'h34);
    final_report();
  end
endmodule // dnc_tb_top
`default_nettype wire

// ---- dv/dnc_top_sva.sv ----
// assertion checker for the command interpreter ports
`timescale 1ns/1ps
`default_nettype none
module dnc_top_sva
  import dnc_pkg::*;
#(
  parameter int KEY_W = DNC_KEY_W
) (
  input wire logic             ref_clk, // clock
  input wire logic             reset_n, // reset, active low
  input wire logic             psel,    // apb select
  input wire logic             penable, // apb enable
  input wire logic             pwrite,  // apb direction
  input wire logic [11:0]      paddr,   // apb address
  input wire logic [31:0]      pwdata,  // apb write data
  input wire logic [31:0]      prdata,  // apb read data
  input wire logic             pready,  // apb ready
  input wire logic             pslverr, // apb error
  input wire logic [KEY_W-1:0] key_in,  // key levels
  input wire dnc_disp_t        disp,    // display write
  input wire dnc_cursor_t      cursor,  // cursor
  input wire logic [31:0]      dig_out  // digital outputs
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // completed write of the launch bit to the control register, accepted or refused
  wire logic go_w = psel && penable && pready && pwrite && (paddr == DNC_CTRL_OFS) && pwdata[0];
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_two_wr;
    disp.we ##1 disp.we;
  endsequence
  property p_rdy_wait;
    s_wait |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready held");
  property p_err_rdy;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_disp_range;
    disp.we |-> disp.addr <= DNC_DISP_LAST;
  endproperty
  a_disp_range: assert property (p_disp_range) else $error("write off display");
  property p_disp_nul;
    disp.we |-> disp.chr != 8'h00;
  endproperty
  a_disp_nul: assert property (p_disp_nul) else $error("null written");
  property p_disp_seq;
    s_two_wr |-> disp.addr == $past(disp.addr) + 7'h01;
  endproperty
  a_disp_seq: assert property (p_disp_seq) else $error("copy not consecutive");
  property p_cur_range;
    cursor.on |-> cursor.pos <= DNC_DISP_LAST;
  endproperty
  a_cur_range: assert property (p_cur_range) else $error("cursor off display");
  property p_dout_go;
    !$stable(dig_out) |-> $past(go_w) || $past(go_w, 2);
  endproperty
  a_dout_go: assert property (p_dout_go) else $error("outputs moved without launch");
endmodule // dnc_top_sva
bind dnc_top dnc_top_sva #(.KEY_W(KEY_W)) dnc_top_sva_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .key_in(key_in), .disp(disp),
  .cursor(cursor), .dig_out(dig_out)
);
`default_nettype wire

// ---- verilog/dnc_key_edge.sv ----
// keypad synchroniser and press detector
`timescale 1ns/1ps
`default_nettype none
module dnc_key_edge #(
  parameter int W = 18
) (
  input  wire logic         ref_clk,   // device clock
  input  wire logic         reset_n,   // sync reset, active low
  input  wire logic [W-1:0] key_in,    // raw key levels from the panel
  output logic      [W-1:0] key_lvl,   // synchronised key levels
  output logic      [W-1:0] key_press  // one-cycle press pulses
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] last_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_key
      // first stage feeds only the second one
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
          last_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= key_in[i];
          sync_ff[i] <= meta_ff[i];
          last_ff[i] <= sync_ff[i];
        end
      end
      assign key_press[i] = sync_ff[i] & ~last_ff[i];
    end
  endgenerate

  assign key_lvl = sync_ff;

endmodule // dnc_key_edge
`default_nettype wire

// ---- verilog/dnc_pkg.sv ----
// constants and carrier types for the display and numeric entry command block
package dnc_pkg;

  // register byte offsets
  localparam logic [11:0] DNC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] DNC_STAT_OFS   = 12'h004;
  localparam logic [11:0] DNC_KEYS_OFS   = 12'h008;
  localparam logic [11:0] DNC_DOUT_OFS   = 12'h00C;
  localparam logic [11:0] DNC_CBUF_BASE  = 12'h100;
  localparam logic [11:0] DNC_RESP_BASE  = 12'h300;

  // command buffer layout
  localparam int          DNC_CBUF_LEN   = 88;
  localparam int          DNC_RESP_LEN   = 20;
  localparam logic [6:0]  DNC_BYTE_START = 7'h01;
  localparam logic [6:0]  DNC_BYTE_DATTR = 7'h02;
  localparam logic [6:0]  DNC_BYTE_MAXL  = 7'h02;
  localparam logic [6:0]  DNC_BYTE_NATTR = 7'h03;
  localparam logic [6:0]  DNC_BYTE_DATA  = 7'h03;
  localparam logic [6:0]  DNC_BYTE_DOUT  = 7'h54;

  // command and response codes
  localparam logic [3:0]  DNC_CMD_DISP   = 4'h1;
  localparam logic [3:0]  DNC_CMD_NUM    = 4'h2;
  localparam logic [3:0]  DNC_RSP_NUM    = 4'h2;

  // display geometry and special values
  localparam logic [6:0]  DNC_DISP_LAST  = 7'h4F;
  localparam logic [6:0]  DNC_DISP_CHARS = 7'h50;
  localparam logic [7:0]  DNC_NO_ECHO    = 8'hFF;
  localparam logic [4:0]  DNC_MAXL_MAX   = 5'h14;
  localparam logic [4:0]  DNC_MAXL_MIN   = 5'h01;
  localparam logic [7:0]  DNC_CH_ZERO    = 8'h30;
  localparam logic [7:0]  DNC_CH_DOT     = 8'h2E;
  localparam logic [7:0]  DNC_CH_MINUS   = 8'h2D;
  localparam logic [7:0]  DNC_CH_SPACE   = 8'h20;

  // numeric entry attribute bit positions
  localparam int          DNC_AT_BLOCK   = 0;
  localparam int          DNC_AT_FLASH   = 1;
  localparam int          DNC_AT_ECHO    = 2;
  localparam int          DNC_AT_FLOAT   = 3;
  localparam int          DNC_AT_SIGN    = 4;

  // key vector bit positions (digits occupy 0..9)
  localparam int          DNC_KEY_W      = 18;
  localparam int          DNC_KEY_LEFT   = 12;
  localparam int          DNC_KEY_SEND   = 14;
  localparam int          DNC_KEY_SIGN   = 16;
  localparam int          DNC_KEY_DOT    = 17;

  // status register fields
  localparam int          DNC_ST_BUSY    = 0;
  localparam int          DNC_ST_RVALID  = 1;
  localparam int          DNC_ST_ENTRY   = 2;

  typedef enum logic [1:0] {
    DNC_IDLE  = 2'b00,
    DNC_COPY  = 2'b01,
    DNC_ENTRY = 2'b10
  } dnc_state_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] chr;
    logic [7:0] alt;
  } dnc_disp_t;

  typedef struct packed {
    logic       on;
    logic [6:0] pos;
    logic       block;
    logic       flash;
  } dnc_cursor_t;

endpackage

// ---- verilog/dnc_top.sv ----
// display write and numeric entry command interpreter with APB registers
//
// Contract
// - display write starts at the start-position byte, legal zero to seventy-nine
// - attribute zero shows written characters steadily
// - nonzero attribute alternates each character with the attribute code
// - attribute underscore code alternates characters with underscore
// - copy characters until a zero byte or eighty characters; the code also stops past the last display cell
// - numeric entry is code two; bytes give start, length, attributes, outputs
// - numeric entry uses five bytes plus the digital output bytes only; the code reads four, bytes 0 to 3
// - entry echo starts at the start-position byte
// - start-position all ones suppresses all echo
// - record at most the maximum-length count, discard further keys
// - cursor shape bit: one block, zero underscore
// - cursor blink bit: one blinking, zero solid
// - echo bit: one shows keystrokes, zero hides them
// - sign bit enables plus/minus key, else ignored
// - decimal bit enables decimal point key, else ignored
// - left arrow removes last recorded character
// - send key ends entry and returns digit string as response
// - response only on completion; key states reported continuously
`timescale 1ns/1ps
`default_nettype none
module dnc_top
  import dnc_pkg::*;
#(
  parameter int KEY_W = DNC_KEY_W
) (
  input  wire logic             ref_clk,     // 125 MHz device clock
  input  wire logic             reset_n,     // sync reset, active low
  input  wire logic             psel,        // apb select
  input  wire logic             penable,     // apb enable
  input  wire logic             pwrite,      // apb direction
  input  wire logic [11:0]      paddr,       // apb byte address
  input  wire logic [31:0]      pwdata,      // apb write data
  output logic      [31:0]      prdata,      // apb read data
  output logic                  pready,      // apb ready
  output logic                  pslverr,     // apb error on unmapped address
  input  wire logic [KEY_W-1:0] key_in,      // raw keypad levels
  output var dnc_disp_t         disp,        // display character write
  output var dnc_cursor_t       cursor,      // entry cursor
  output logic      [31:0]      dig_out      // digital output bytes
);

  dnc_state_t  state_ff;
  logic [7:0]  cbuf_ff [DNC_CBUF_LEN];
  logic [7:0]  resp_ff [DNC_RESP_LEN];
  logic [6:0]  idx_ff;
  logic [7:0]  start_ff;
  logic [7:0]  attr_ff;
  logic [4:0]  max_ff;
  logic [4:0]  len_ff;
  logic        rvalid_ff;
  logic [4:0]  rlen_ff;
  logic [31:0] dout_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  dnc_disp_t   disp_ff;
  dnc_cursor_t cursor_ff;
  dnc_disp_t   nxt_disp;

  logic [KEY_W-1:0] key_lvl;
  logic [KEY_W-1:0] key_press;

  dnc_key_edge #(
    .W (KEY_W)
  ) u_keys (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .key_in    (key_in),
    .key_lvl   (key_lvl),
    .key_press (key_press)
  );

  // apb decode; one wait state so read data comes from a flop
  wire        acc_first = psel & penable & ~pready_ff;
  // a write lands at the edge where pready is seen high
  wire        wr_done   = psel & penable & pready_ff & pwrite;
  wire [11:0] buf_off   = paddr - DNC_CBUF_BASE;
  wire [11:0] rsp_off   = paddr - DNC_RESP_BASE;
  wire [6:0]  buf_idx   = buf_off[8:2];
  wire [4:0]  rsp_idx   = rsp_off[6:2];
  wire        al        = (paddr[1:0] == 2'b00);
  wire        hit_ctrl  = (paddr == DNC_CTRL_OFS);
  wire        hit_stat  = (paddr == DNC_STAT_OFS);
  wire        hit_keys  = (paddr == DNC_KEYS_OFS);
  wire        hit_dout  = (paddr == DNC_DOUT_OFS);
  wire        hit_buf   = al && (paddr >= DNC_CBUF_BASE)
                          && (buf_off < 12'(4 * DNC_CBUF_LEN));
  wire        hit_rsp   = al && (paddr >= DNC_RESP_BASE)
                          && (rsp_off < 12'(4 * DNC_RESP_LEN));
  wire        hit_any   = hit_ctrl | hit_stat | hit_keys | hit_dout | hit_buf | hit_rsp;

  // status flags; busy covers both copy and entry
  wire        st_busy   = (state_ff != DNC_IDLE);
  wire        st_entry  = (state_ff == DNC_ENTRY);
  wire [31:0] stat_word = {12'h000, DNC_RSP_NUM, 3'b000, rlen_ff, 5'b00000,
                           st_entry, rvalid_ff, st_busy};
  // key levels readable at any time
  wire [31:0] keys_word = {{(32-KEY_W){1'b0}}, key_lvl};
  wire [31:0] rd_data   = hit_stat ? stat_word :
                          hit_keys ? keys_word :
                          hit_dout ? dout_ff :
                          hit_buf  ? {24'h000000, cbuf_ff[buf_idx]} :
                          hit_rsp  ? {24'h000000, resp_ff[rsp_idx]} : 32'h00000000;

  // command launch, only from idle
  wire        go        = wr_done & hit_ctrl & pwdata[0] & (state_ff == DNC_IDLE);
  wire [3:0]  cmd_code  = cbuf_ff[0][3:0];
  wire        rv_clr    = wr_done & hit_stat & pwdata[DNC_ST_RVALID];
  wire [7:0]  b_start   = cbuf_ff[DNC_BYTE_START];
  wire [7:0]  b_maxl    = cbuf_ff[DNC_BYTE_MAXL];
  // maximum length clamped into one to twenty
  wire [4:0]  maxl_cl   = (b_maxl == 8'h00) ? DNC_MAXL_MIN :
                          (b_maxl > {3'b000, DNC_MAXL_MAX}) ? DNC_MAXL_MAX : b_maxl[4:0];
  // launch decoded per command code; other codes only reload the start byte and refresh the outputs
  wire        go_disp   = go & (cmd_code == DNC_CMD_DISP);
  wire        go_num    = go & (cmd_code == DNC_CMD_NUM);

  // output bytes in buffer order, lowest byte in bits 7:0
  logic [31:0] dout_new;
  genvar       gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_dout
      assign dout_new[8*gb +: 8] = cbuf_ff[DNC_BYTE_DOUT + 7'(gb)];
    end
  endgenerate

  // display copy step
  // one buffer byte per cycle, so a full line takes eighty cycles
  wire [6:0]  copy_src  = idx_ff + DNC_BYTE_DATA;
  wire [7:0]  copy_ch   = cbuf_ff[copy_src];
  wire [7:0]  copy_pos  = start_ff + {1'b0, idx_ff};
  // stop at zero byte, after eighty characters or past the last display cell
  wire        copy_end  = (idx_ff == DNC_DISP_CHARS) || (copy_ch == 8'h00)
                          || (copy_pos > {1'b0, DNC_DISP_LAST});

  // numeric entry key decode
  // lowest digit wins when several are pressed in one cycle
  logic       dig_hit;
  logic [3:0] dig_val;
  always_comb begin
    dig_hit = 1'b0;
    dig_val = 4'h0;
    for (int d = 9; d >= 0; d--) begin
      if (key_press[d]) begin
        dig_hit = 1'b1;
        dig_val = 4'(d);
      end
    end
  end

  wire        at_sign   = attr_ff[DNC_AT_SIGN];
  wire        at_float  = attr_ff[DNC_AT_FLOAT];
  wire        at_echo   = attr_ff[DNC_AT_ECHO];
  wire        in_entry  = (state_ff == DNC_ENTRY);
  // send outranks left and character keys seen in the same cycle
  wire        k_send    = in_entry & key_press[DNC_KEY_SEND];
  wire        k_left    = in_entry & ~k_send & key_press[DNC_KEY_LEFT];
  // backspace only acts once something was recorded
  wire        k_back    = k_left & (len_ff != 5'd0);
  wire        k_sign    = key_press[DNC_KEY_SIGN] & at_sign;
  // decimal point only with float enabled
  wire        k_dot     = key_press[DNC_KEY_DOT] & at_float;
  wire        has_char  = dig_hit | k_sign | k_dot;
  wire [7:0]  new_ch    = dig_hit ? (DNC_CH_ZERO + {4'h0, dig_val}) :
                          k_dot   ? DNC_CH_DOT : DNC_CH_MINUS;
  // further keys beyond the limit are dropped
  wire        k_char    = in_entry & ~k_send & ~k_left & has_char & (len_ff < max_ff);
  wire [4:0]  len_dec   = len_ff - 5'd1;
  wire [4:0]  echo_len  = k_left ? len_dec : len_ff;
  wire [7:0]  echo_pos  = start_ff + {3'b000, echo_len};
  // start inside the display; keeps the 8-bit position sums from wrapping
  wire        start_ok  = (start_ff <= {1'b0, DNC_DISP_LAST});
  // echo needs echo bit and a real start position
  wire        echo_on   = at_echo && start_ok && (start_ff != DNC_NO_ECHO);
  // echo position counts from the start byte
  wire        echo_ok   = echo_on && (echo_pos <= {1'b0, DNC_DISP_LAST});
  wire [7:0]  cur_pos   = start_ff + {3'b000, len_ff};

  // cursor sits on the next free cell; hidden as soon as send is seen
  dnc_cursor_t nxt_cursor;
  assign nxt_cursor.on    = in_entry && !k_send && echo_on
                            && (cur_pos <= {1'b0, DNC_DISP_LAST});
  assign nxt_cursor.pos   = cur_pos[6:0];
  assign nxt_cursor.block = attr_ff[DNC_AT_BLOCK];
  assign nxt_cursor.flash = attr_ff[DNC_AT_FLASH];

  // display write selection
  always_comb begin
    nxt_disp = '0;
    if (state_ff == DNC_COPY && !copy_end) begin
      nxt_disp.we   = 1'b1;
      nxt_disp.addr = copy_pos[6:0];
      nxt_disp.chr  = copy_ch;
      nxt_disp.alt  = attr_ff;
    end else if (k_char && echo_ok) begin
      nxt_disp.we   = 1'b1;
      nxt_disp.addr = echo_pos[6:0];
      nxt_disp.chr  = new_ch;
    end else if (k_back && echo_ok) begin
      nxt_disp.we   = 1'b1;
      nxt_disp.addr = echo_pos[6:0];
      nxt_disp.chr  = DNC_CH_SPACE;
    end
  end

  // apb slave timing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= acc_first;
      pslverr_ff <= acc_first & ~hit_any;
      prdata_ff  <= acc_first ? rd_data : 32'h00000000;
    end
  end

  // command buffer written by software; no reset needed for data bytes
  always_ff @(posedge ref_clk) begin
    if (wr_done && hit_buf) begin
      cbuf_ff[buf_idx] <= pwdata[7:0];
    end
  end

  // command fields captured at launch, held for the whole command
  // a refused launch while busy leaves them alone
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      start_ff <= 8'h00;
      attr_ff  <= 8'h00;
      max_ff   <= DNC_MAXL_MIN;
      dout_ff  <= 32'h00000000;
    end else begin
      if (go) begin
        // digital output bytes follow every command
        dout_ff  <= dout_new;
        start_ff <= b_start;
      end
      if (go_disp) begin
        attr_ff <= cbuf_ff[DNC_BYTE_DATTR];
      end else if (go_num) begin
        // length and attribute bytes here; start and output bytes are taken above for every command
        max_ff  <= maxl_cl;
        attr_ff <= cbuf_ff[DNC_BYTE_NATTR];
      end
    end
  end

  // main sequencer
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_ff <= DNC_IDLE;
      idx_ff   <= 7'h00;
    end else begin
      unique case (state_ff)
        DNC_IDLE: begin
          idx_ff <= 7'h00;
          if (go_disp) begin
            state_ff <= DNC_COPY;
          end else if (go_num) begin
            state_ff <= DNC_ENTRY;
          end
        end
        DNC_COPY: begin
          if (copy_end) begin
            state_ff <= DNC_IDLE;
          end else begin
            idx_ff <= idx_ff + 7'd1;
          end
        end
        DNC_ENTRY: begin
          if (k_send) begin
            state_ff <= DNC_IDLE;
          end
        end
        default: state_ff <= DNC_IDLE;
      endcase
    end
  end

  // entry recording and response
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      len_ff    <= 5'd0;
      rvalid_ff <= 1'b0;
      rlen_ff   <= 5'd0;
    end else begin
      if (go && cmd_code == DNC_CMD_NUM) begin
        len_ff <= 5'd0;
      end else if (k_char) begin
        len_ff <= len_ff + 5'd1;
      end else if (k_back) begin
        len_ff <= len_dec;
      end
      // response raised only at entry completion; set beats clear
      if (k_send) begin
        rvalid_ff <= 1'b1;
        rlen_ff   <= len_ff;
      end else if (rv_clr) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // response slots are not reset; the status length says how many count
  always_ff @(posedge ref_clk) begin
    if (k_char) begin
      resp_ff[len_ff] <= new_ch;
    end
  end

  // display and cursor outputs
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      disp_ff   <= '0;
      cursor_ff <= '0;
    end else begin
      disp_ff   <= nxt_disp;
      cursor_ff <= nxt_cursor;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign disp    = disp_ff;
  assign cursor  = cursor_ff;
  assign dig_out = dout_ff;

endmodule // dnc_top
`default_nettype wire
